// File: smlp_pkg.sv
// constants for the always-on supply monitor and low-power control bank
package smlp_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_P0_FL = 8'h04;
	localparam logic [7:0] OFF_P0_EN = 8'h08;
	localparam logic [7:0] OFF_P1_FL = 8'h0c;
	localparam logic [7:0] OFF_P1_EN = 8'h10;
	localparam logic [7:0] OFF_P2_FL = 8'h14;
	localparam logic [7:0] OFF_P2_EN = 8'h18;
	localparam logic [7:0] OFF_P3_FL = 8'h1c;
	localparam logic [7:0] OFF_P3_EN = 8'h20;
	localparam logic [7:0] OFF_USB_FL = 8'h30;
	localparam logic [7:0] OFF_USB_EN = 8'h34;
	localparam logic [7:0] OFF_MEM = 8'h40;
	localparam logic [7:0] OFF_ACK = 8'h44;
	// control register and sub-second counter bit positions
	localparam int BIT_USB = 27;
	localparam int BIT_IOH = 24;
	localparam int BIT_IO = 23;
	localparam int BIT_ANA = 22;
	localparam int BIT_RTC = 21;
	localparam int BIT_CORE = 20;
	localparam int SSEC_TOP = 11;
	localparam int SSEC_ANA = 10;
	localparam int SSEC_RTC = 9;
	localparam int SSEC_CORE = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_1800;
	localparam logic [31:0] CTRL_WMASK = 32'h0fff_ffff;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	// supply index order in the trip vectors
	localparam int SUP_CORE = 0;
	localparam int SUP_IO = 1;
	localparam int SUP_IOH = 2;
	localparam int SUP_ANA = 3;
	localparam int SUP_RTC = 4;
	localparam int SUP_USB = 5;
	localparam int NSUP = 6;
endpackage

// File: smlp_sync.sv
// two-flop level synchroniser
module smlp_sync (
	input wire logic mclk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);
	logic s1_q, s1_d, s2_q, s2_d;
	// first stage feeds only the second
	always_comb begin
		s1_d = din;
		s2_d = s1_q;
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end
	assign dout = s2_q;
endmodule

// File: smlp_regfile.sv
// word register with write strobe, cleared only by power-on reset
module smlp_regfile #(
	parameter logic [31:0] RST = 32'h0000_0000
) (
	input wire logic mclk,
	input wire logic por,
	input wire logic wr,
	input wire logic [31:0] wdata,
	output logic [31:0] q
);
	logic [31:0] r_q, r_d;
	always_comb begin
		r_d = wr ? wdata : r_q;
	end
	// only power-on reset clears it
	always_ff @(posedge mclk) begin
		if (por) begin
			r_q <= RST;
		end else begin
			r_q <= r_d;
		end
	end
	assign q = r_q;
endmodule

// File: smlp_top.sv
// supply monitor trip handling and always-on low-power register bank
module smlp_top (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [5:0] supply_low,
	input wire logic [5:0] powerfail_low,
	input wire logic [11:0] rtc_subsecond_counter,
	input wire logic bus_sel,
	input wire logic bus_wr,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	output logic [31:0] bus_rdata,
	output logic [5:0] domain_reset,
	output logic device_por,
	output logic powerfail_irq
);
	logic wr_ctrl, wr_mem, ack_wr, irq_sync, trip_any;
	logic [31:0] ctrl_q, mem_q;
	logic [31:0] fl_q [5];
	logic [31:0] en_q [5];
	logic [7:0] fl_off [5];
	logic [7:0] en_off [5];
	logic [5:0] mon_en;
	logic [5:0] dom_d, dom_q;
	logic por_d, por_q;
	logic warn_d, warn_q;
	logic irq_d, irq_q;
	logic [31:0] rd_d, rd_q;

	assign fl_off = '{smlp_pkg::OFF_P0_FL, smlp_pkg::OFF_P1_FL,
		smlp_pkg::OFF_P2_FL, smlp_pkg::OFF_P3_FL, smlp_pkg::OFF_USB_FL};
	assign en_off = '{smlp_pkg::OFF_P0_EN, smlp_pkg::OFF_P1_EN,
		smlp_pkg::OFF_P2_EN, smlp_pkg::OFF_P3_EN, smlp_pkg::OFF_USB_EN};

	// write strobes; reserved high nibble masked off on write
	assign wr_ctrl = bus_sel && bus_wr && bus_addr == smlp_pkg::OFF_CTRL;
	assign wr_mem = bus_sel && bus_wr && bus_addr == smlp_pkg::OFF_MEM;
	assign ack_wr = bus_sel && bus_wr && bus_addr == smlp_pkg::OFF_ACK;

	// power-on reset is the bank's reset; the device por output does not clear it
	smlp_regfile #(.RST(smlp_pkg::CTRL_RST)) u_ctrl (
		.mclk(mclk),
		.por(reset),
		.wr(wr_ctrl),
		.wdata(bus_wdata & smlp_pkg::CTRL_WMASK),
		.q(ctrl_q)
	);
	smlp_regfile #(.RST(smlp_pkg::REG_RST)) u_mem (
		.mclk(mclk),
		.por(reset),
		.wr(wr_mem),
		.wdata(bus_wdata),
		.q(mem_q)
	);
	// wakeup flag and enable pairs, gpio 0-3 then usb
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_wk
			smlp_regfile #(.RST(smlp_pkg::REG_RST)) u_fl (
				.mclk(mclk),
				.por(reset),
				.wr(bus_sel && bus_wr && bus_addr == fl_off[g]),
				.wdata(bus_wdata),
				.q(fl_q[g])
			);
			smlp_regfile #(.RST(smlp_pkg::REG_RST)) u_en (
				.mclk(mclk),
				.por(reset),
				.wr(bus_sel && bus_wr && bus_addr == en_off[g]),
				.wdata(bus_wdata),
				.q(en_q[g])
			);
		end
	endgenerate

	// a set disable bit turns that monitor off; software should keep zero
	always_comb begin
		mon_en[smlp_pkg::SUP_CORE] = !ctrl_q[smlp_pkg::BIT_CORE];
		mon_en[smlp_pkg::SUP_IO] = !ctrl_q[smlp_pkg::BIT_IO];
		mon_en[smlp_pkg::SUP_IOH] = !ctrl_q[smlp_pkg::BIT_IOH];
		mon_en[smlp_pkg::SUP_ANA] = !ctrl_q[smlp_pkg::BIT_ANA];
		mon_en[smlp_pkg::SUP_RTC] = !ctrl_q[smlp_pkg::BIT_RTC];
		mon_en[smlp_pkg::SUP_USB] = !ctrl_q[smlp_pkg::BIT_USB];
	end

	// trip actions: domain resets, device por, sticky warning
	always_comb begin
		dom_d = supply_low & mon_en;
		por_d = (powerfail_low[smlp_pkg::SUP_CORE]
			&& mon_en[smlp_pkg::SUP_CORE])
			|| (powerfail_low[smlp_pkg::SUP_ANA]
			&& mon_en[smlp_pkg::SUP_ANA])
			|| (powerfail_low[smlp_pkg::SUP_RTC]
			&& mon_en[smlp_pkg::SUP_RTC]);
		trip_any = |dom_d || por_d;
		// a new trip wins over an acknowledge in the same cycle
		warn_d = trip_any || (warn_q && !ack_wr);
		irq_d = irq_sync;
	end

	smlp_sync u_sync (
		.mclk(mclk),
		.reset(reset),
		.din(warn_q),
		.dout(irq_sync)
	);

	// read mux; io, ana, rtc and core disable bits read back sub-second counter bits 11-8
	always_comb begin
		rd_d = 32'h0000_0000;
		if (bus_sel && !bus_wr) begin
			if (bus_addr == smlp_pkg::OFF_CTRL) begin
				rd_d = ctrl_q & smlp_pkg::CTRL_WMASK;
				rd_d[smlp_pkg::BIT_IO] =
					rtc_subsecond_counter[smlp_pkg::SSEC_TOP];
				rd_d[smlp_pkg::BIT_ANA] =
					rtc_subsecond_counter[smlp_pkg::SSEC_ANA];
				rd_d[smlp_pkg::BIT_RTC] =
					rtc_subsecond_counter[smlp_pkg::SSEC_RTC];
				rd_d[smlp_pkg::BIT_CORE] =
					rtc_subsecond_counter[smlp_pkg::SSEC_CORE];
			end else if (bus_addr == smlp_pkg::OFF_MEM) begin
				rd_d = mem_q;
			end else if (bus_addr == smlp_pkg::OFF_ACK) begin
				rd_d = {31'h0, warn_q};
			end
			for (int i = 0; i < 5; i++) begin
				if (bus_addr == fl_off[i]) begin
					rd_d = fl_q[i];
				end
				if (bus_addr == en_off[i]) begin
					rd_d = en_q[i];
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			dom_q <= 6'h00;
			por_q <= 1'b0;
			warn_q <= 1'b0;
			irq_q <= 1'b0;
			rd_q <= 32'h0000_0000;
		end else begin
			dom_q <= dom_d;
			por_q <= por_d;
			warn_q <= warn_d;
			irq_q <= irq_d;
			rd_q <= rd_d;
		end
	end

	assign bus_rdata = rd_q;
	assign domain_reset = dom_q;
	assign device_por = por_q;
	assign powerfail_irq = irq_q;
endmodule

// File: smlp_chk.sv
// port checker for the supply monitor bank
module smlp_chk (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [5:0] supply_low,
	input wire logic [5:0] powerfail_low,
	input wire logic [11:0] rtc_subsecond_counter,
	input wire logic bus_sel,
	input wire logic bus_wr,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic [5:0] domain_reset,
	input wire logic device_por,
	input wire logic powerfail_irq
);
	logic rd_ctrl;
	// checks assume all disable bits stay zero, so monitors stay on
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	// read of the control word
	assign rd_ctrl = bus_sel & !bus_wr & (bus_addr == 8'h00);
	a_domain_follow: assert property (
		!$past(reset) |-> domain_reset == $past(supply_low)) else $error("dom");
	a_usb_domain: assert property (
		supply_low[5] |=> domain_reset[5]) else $error("usb dom");
	a_ioh_domain: assert property (
		supply_low[2] |=> domain_reset[2]) else $error("ioh dom");
	a_por_trip: assert property (
		!$past(reset) |-> device_por == $past(powerfail_low[0]
		| powerfail_low[3] | powerfail_low[4])) else $error("por");
	a_irq_trip: assert property (
		|supply_low |-> ##4 powerfail_irq) else $error("irq late");
	a_pf_warn: assert property (
		(powerfail_low[0] | powerfail_low[3] | powerfail_low[4])
		|-> ##4 powerfail_irq) else $error("pf irq late");
	a_irq_ack_only: assert property (
		$fell(powerfail_irq) |-> $past(bus_sel & bus_wr
		& (bus_addr == 8'h44), 4)) else $error("irq drop");
	a_idle_zero: assert property (
		!(bus_sel & !bus_wr) |=> bus_rdata == 32'h0) else $error("idle");
	a_ctrl_rsvd: assert property (
		rd_ctrl |=> bus_rdata[31:28] == 4'h0) else $error("rsvd");
	a_ssec_top: assert property (
		rd_ctrl |=> bus_rdata[23] == $past(rtc_subsecond_counter[11]))
		else $error("ssec");
endmodule
bind smlp_top smlp_chk i_smlp_chk (.mclk(mclk), .reset(reset),
	.supply_low(supply_low), .powerfail_low(powerfail_low),
	.rtc_subsecond_counter(rtc_subsecond_counter), .bus_sel(bus_sel),
	.bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata), .domain_reset(domain_reset),
	.device_por(device_por), .powerfail_irq(powerfail_irq));

// File: tb.sv
// self-checking bench for the supply monitor bank
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, reset = 1, bus_sel = 0, bus_wr = 0, device_por;
	logic powerfail_irq;
	logic [5:0] supply_low = 0, powerfail_low = 0, domain_reset;
	logic [11:0] rtc_subsecond_counter = 12'hc00;
	logic [7:0] bus_addr = 0;
	logic [31:0] bus_wdata = 0, bus_rdata, d, base;
	logic [7:0] offs [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h1c, 8'h20, 8'h30, 8'h34, 8'h40};
	int err_count = 0, tests_run = 0;
	// 100 ns clock
	always #50 mclk = ~mclk;
	smlp_top i_smlp_top (.mclk(mclk), .reset(reset),
		.supply_low(supply_low), .powerfail_low(powerfail_low),
		.rtc_subsecond_counter(rtc_subsecond_counter), .bus_sel(bus_sel),
		.bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .domain_reset(domain_reset),
		.device_por(device_por), .powerfail_irq(powerfail_irq));
	task automatic report_and_stop;
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	// one-cycle bus access, request held over its taking edge
	task automatic acc(logic w, logic [7:0] a, logic [31:0] v);
		@(negedge mclk);
		bus_sel = 1;
		bus_wr = w;
		bus_addr = a;
		bus_wdata = v;
		@(negedge mclk);
		bus_sel = 0;
		d = bus_rdata;
	endtask
	task automatic wait_irq(logic v);
		for (int k = 0; k < 12 && powerfail_irq !== v; k++)
			@(negedge mclk);
		chk("irq", {31'h0, v}, {31'h0, powerfail_irq});
		if (powerfail_irq !== v)
			report_and_stop;
	endtask
	// every register except the acknowledge word read back against its expected word
	task automatic t_regs(logic [31:0] cw, logic [31:0] ow);
		for (int i = 0; i < 12; i++) begin
			acc(0, offs[i], 0);
			// a cleared bank reads zero; written words carry their offset
			base = (i == 0) ? cw : ((ow == 0) ? 32'h0 : (ow | offs[i]));
			if (i == 0)
				base[23:20] = rtc_subsecond_counter[11:8];
			chk("reg", base, d);
		end
		acc(0, 8'h24, 0);
		chk("unmapped", 0, d);
	endtask
	// writes, refused reserved bits, then a power-on reset returns every register to its reset word
	task automatic t_write;
		for (int i = 0; i < 12; i++)
			acc(1, offs[i], i ? {24'h5a5a5a, offs[i]} : 32'hf000_0200);
		acc(1, 8'h24, 32'hffff_ffff);
		rtc_subsecond_counter = 12'h300;
		t_regs(32'h0000_0200, 32'h5a5a_5a00);
		reset = 1;
		repeat (10) @(negedge mclk);
		reset = 0;
		t_regs(32'h0000_1800, 0);
	endtask
	// each supply trips its domain and the warning, then acknowledged
	task automatic t_trip;
		for (int i = 0; i < 6; i++) begin
			supply_low = 6'h1 << i;
			@(negedge mclk);
			chk("domain", 6'h1 << i, domain_reset);
			wait_irq(1);
			supply_low = 0;
			acc(0, 8'h44, 0);
			chk("warn", 1, {31'h0, d[0]});
			acc(1, 8'h44, 0);
			wait_irq(0);
			// power-fail trip; warning acknowledged so the next trip is seen
			powerfail_low = 6'h1 << i;
			@(negedge mclk);
			chk("por", (i == 0 || i == 3 || i == 4), device_por);
			powerfail_low = 0;
			wait_irq(i == 0 || i == 3 || i == 4);
			acc(1, 8'h44, 0);
			wait_irq(0);
		end
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		reset = 0;
		t_regs(32'h0000_1800, 0);
		t_write;
		t_trip;
		report_and_stop;
	end
endmodule
